// ===== include/lfs_params.svh
// Purpose: Timing counts and pin vector layout of the fault supervisor
// Assumes: mclk at 250 MHz
// Notes: Long counts are defaults of top-level parameters
`ifndef LFS_PARAMS_SVH
`define LFS_PARAMS_SVH

// Clock period and documented times, each in its own unit
`define LFS_CLK_PERIOD_NS 4
`define LFS_CLEAR_TIME_MS 16
`define LFS_LOCKOUT_TIME_US 50
`define LFS_SHUTDOWN_TIME_US 3

// Derived cycle counts
`define LFS_CLEAR_CYC (`LFS_CLEAR_TIME_MS * 1000000 / `LFS_CLK_PERIOD_NS)
`define LFS_LOCKOUT_CYC (`LFS_LOCKOUT_TIME_US * 1000 / `LFS_CLK_PERIOD_NS)
`define LFS_SHUTDOWN_CYC (`LFS_SHUTDOWN_TIME_US * 1000 / `LFS_CLK_PERIOD_NS)

// Counter width and switching clock half period
`define LFS_CNT_W 23
`define LFS_SW_HALF 7'h3F
`define LFS_SKIP_PERIODS 2'h2

// Fields of the synchronised pin vector
`define LFS_PIN_W 22
`define LFS_P_EN 21
`define LFS_P_DIM 20
`define LFS_P_VAR 19
`define LFS_P_SHORT 15
`define LFS_P_REG 11
`define LFS_P_NOCUR 7
`define LFS_P_OV 6
`define LFS_P_OVREL 5
`define LFS_P_SOV 4
`define LFS_P_CYC 3
`define LFS_P_SIL 2
`define LFS_P_IOCP 1
`define LFS_P_LOCK 0

`endif

// ===== include/lfs_pkg.sv
// Purpose: Types shared by the fault supervisor files
// Assumes: lfs_params.svh supplies the widths
// Notes: Holds types only
`include "lfs_params.svh"

package lfs_pkg;

  // Power state, one-hot
  typedef enum logic [2:0]
  {
    ST_SLEEP = 3'b001,
    ST_LOCKOUT = 3'b010,
    ST_ACTIVE = 3'b100
  } lfs_state_e;

  typedef logic [3:0] lfs_chan_t;
  typedef logic [`LFS_CNT_W-1:0] lfs_count_t;

endpackage : lfs_pkg

// ===== include/lfs_timer_if.sv
// Purpose: Link between the supervisor and a low-time timer
// Assumes: One timer per interface instance
// Notes: Owner arms and sets the limit, timer reports expiry
`timescale 1ns/100ps

interface lfs_timer_if;
  logic arm;
  lfs_pkg::lfs_count_t limit;
  logic expired;
  modport owner (output arm, output limit, input expired);
  modport timer (input arm, input limit, output expired);
endinterface : lfs_timer_if

// ===== core/lfs_low_timer.sv
// Purpose: Qualifies how long a condition has held
// Assumes: arm comes from logic on mclk
// Notes: Expired stays high while armed past the limit
`timescale 1ns/100ps
`include "lfs_params.svh"

module lfs_low_timer
(
  input wire logic mclk,
  input wire logic reset,
  lfs_timer_if.timer tif
);

  lfs_pkg::lfs_count_t count;

  // Restart from zero whenever the condition lapses
  always_ff @(posedge mclk)
  begin
    if (reset || !tif.arm)
      count <= '0;
    else if (count != tif.limit)
      count <= count + `LFS_CNT_W'(1);
  end

  assign tif.expired = tif.arm && (count == tif.limit);

  AST_TIMER_RESTART: assert property (@(posedge mclk) disable iff (reset)
    !tif.arm |=> count == '0)
    else $error("timer did not restart");

endmodule : lfs_low_timer

// ===== core/lfs_fault_supervisor.sv
// Purpose: Fault supervision of a four-string boost LED driver
// Assumes: All pin inputs are asynchronous to mclk
// Notes: Comparators of the power stage arrive as level events
`timescale 1ns/100ps
`include "lfs_params.svh"

////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Enable high, dimming low over 16 ms clears latched faults, no sleep.
// - After such a clear, next dimming rise starts a full soft start.
// - Bias supply and switching clock stay on while enable is high.
// - A sink above the short threshold is disabled; other strings run.
// - Standard variant: string short pulls fault low, latched until cleared.
// - Alternate variant: string short disables channel, fault stays high.
// - Short detection armed only while some sink sits at regulation level.
// - Overvoltage event comes from the sense pin current comparator.
// - Overvoltage is not latched and never asserts fault; switching stops.
// - On overvoltage idle strings drop out; boost resumes below 97 percent.
// - Secondary overvoltage stops switching and sinks, latched off.
// - Cycle current limit ends on-time, skips a cycle, sets no fault.
// - Secondary switch current limit shuts down at once, latched off.
// - Input overcurrent shuts down within 3 us, latched, fault set.
// - Input overcurrent turns the disconnect gate off at once.
// - Enable above lockout level; disable after 50 us below it.
// - Enable low 16 ms sleeps; next enable rise clears all latches.
// - Input lockout clears every latched fault and turns boost, sinks and disconnect off.
module lfs_fault_supervisor
#(
  parameter lfs_pkg::lfs_count_t CLEAR_CYC = `LFS_CNT_W'(`LFS_CLEAR_CYC),
  parameter lfs_pkg::lfs_count_t LOCKOUT_CYC = `LFS_CNT_W'(`LFS_LOCKOUT_CYC)
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic enable_pin,
  input wire logic dimming_pin,
  input wire logic variant_alt,
  input wire logic [3:0] string_short_threshold,
  input wire logic [3:0] sink_at_regulation,
  input wire logic [3:0] sink_no_current,
  input wire logic overvoltage_event,
  input wire logic overvoltage_release,
  input wire logic secondary_overvoltage_event,
  input wire logic cycle_current_limit_event,
  input wire logic secondary_switch_current_limit,
  input wire logic input_sense_trip_level,
  input wire logic input_lockout_threshold,
  output logic boost_gate,
  output logic [3:0] sink_enable,
  output logic disconnect_gate_on,
  output logic fault_pin_out,
  output logic fault_pin_oe,
  output logic bias_enable,
  output logic switch_clock_out,
  output logic soft_start_go
);

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [`LFS_PIN_W-1:0] pin_meta;
  logic [`LFS_PIN_W-1:0] pin_sync;

  // Two stages before any logic looks at a pin
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= {enable_pin, dimming_pin, variant_alt, string_short_threshold,
                   sink_at_regulation, sink_no_current, overvoltage_event,
                   overvoltage_release, secondary_overvoltage_event,
                   cycle_current_limit_event, secondary_switch_current_limit,
                   input_sense_trip_level, input_lockout_threshold};
      pin_sync <= pin_meta;
    end
  end

  logic en_s;
  logic dim_s;
  logic var_s;
  lfs_pkg::lfs_chan_t short_s;
  lfs_pkg::lfs_chan_t reg_s;
  lfs_pkg::lfs_chan_t nocur_s;
  logic ov_s;
  logic ovrel_s;
  logic sov_s;
  logic cyc_s;
  logic sil_s;
  logic iocp_s;
  logic lock_s;

  assign en_s = pin_sync[`LFS_P_EN];
  assign dim_s = pin_sync[`LFS_P_DIM];
  assign var_s = pin_sync[`LFS_P_VAR];
  assign short_s = pin_sync[`LFS_P_SHORT +: 4];
  assign reg_s = pin_sync[`LFS_P_REG +: 4];
  assign nocur_s = pin_sync[`LFS_P_NOCUR +: 4];
  assign ov_s = pin_sync[`LFS_P_OV];
  assign ovrel_s = pin_sync[`LFS_P_OVREL];
  assign sov_s = pin_sync[`LFS_P_SOV];
  assign cyc_s = pin_sync[`LFS_P_CYC];
  assign sil_s = pin_sync[`LFS_P_SIL];
  assign iocp_s = pin_sync[`LFS_P_IOCP];
  assign lock_s = pin_sync[`LFS_P_LOCK];

  ////////////////////////////////////////////////////////////////////
  // Low-time timers

  lfs_timer_if en_tif ();
  lfs_timer_if dim_tif ();
  lfs_timer_if lock_tif ();

  // Enable low, dimming low under enable, supply below lockout
  assign en_tif.arm = !en_s;
  assign en_tif.limit = CLEAR_CYC;
  assign dim_tif.arm = en_s && !dim_s;
  assign dim_tif.limit = CLEAR_CYC;
  assign lock_tif.arm = !lock_s;
  assign lock_tif.limit = LOCKOUT_CYC;

  lfs_low_timer u_en_timer (.mclk(mclk), .reset(reset), .tif(en_tif));
  lfs_low_timer u_dim_timer (.mclk(mclk), .reset(reset), .tif(dim_tif));
  lfs_low_timer u_lock_timer (.mclk(mclk), .reset(reset), .tif(lock_tif));

  ////////////////////////////////////////////////////////////////////
  // Power state

  lfs_pkg::lfs_state_e state;
  lfs_pkg::lfs_state_e next_state;
  logic clear_all;

  // Sleep, supply lockout and active operation
  always_comb
  begin
    next_state = state;
    unique case (state)
      lfs_pkg::ST_SLEEP:
        if (en_s)
          next_state = lfs_pkg::ST_LOCKOUT;
      lfs_pkg::ST_LOCKOUT:
        if (en_tif.expired)
          next_state = lfs_pkg::ST_SLEEP;
        else if (lock_s)
          next_state = lfs_pkg::ST_ACTIVE;
      lfs_pkg::ST_ACTIVE:
        if (en_tif.expired)
          next_state = lfs_pkg::ST_SLEEP;
        else if (lock_tif.expired)
          next_state = lfs_pkg::ST_LOCKOUT;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      state <= lfs_pkg::ST_SLEEP;
    else
      state <= next_state;
  end

  // Wake from sleep, long dimming low, or supply lockout
  assign clear_all = ((state == lfs_pkg::ST_SLEEP) && en_s)
                     || dim_tif.expired
                     || (state == lfs_pkg::ST_LOCKOUT);

  ////////////////////////////////////////////////////////////////////
  // Fault latches, set wins over clear

  lfs_pkg::lfs_chan_t short_flag;
  lfs_pkg::lfs_chan_t open_flag;
  lfs_pkg::lfs_chan_t short_set;
  lfs_pkg::lfs_chan_t open_set;
  logic sov_flag;
  logic sil_flag;
  logic iocp_flag;
  logic trip;
  logic latched_any;
  logic set_any;
  logic armed;

  // Short detection needs one string still in regulation
  assign armed = |reg_s;
  assign short_set = short_s & sink_enable & {4{armed}};
  assign open_set = nocur_s & sink_enable & {4{ov_s}};
  assign trip = sov_flag || sil_flag || iocp_flag;
  assign latched_any = trip || (|short_flag) || (|open_flag);
  assign set_any = (|short_set) || (|open_set) || sov_s || sil_s || iocp_s;

  // Per-string removal keeps other strings running
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      short_flag <= '0;
      open_flag <= '0;
    end
    else
    begin
      short_flag <= short_set | (clear_all ? '0 : short_flag);
      open_flag <= open_set | (clear_all ? '0 : open_flag);
    end
  end

  // Latched-off conditions
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      sov_flag <= 1'b0;
      sil_flag <= 1'b0;
      iocp_flag <= 1'b0;
    end
    else
    begin
      sov_flag <= sov_s || (sov_flag && !clear_all);
      sil_flag <= sil_s || (sil_flag && !clear_all);
      iocp_flag <= iocp_s || (iocp_flag && !clear_all);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Overvoltage hold and cycle skip

  logic ov_stop;
  logic [1:0] skip_cnt;
  logic [6:0] sw_cnt;
  logic period_start;

  // Not a latched fault; released by the 97 percent comparator
  always_ff @(posedge mclk)
  begin
    if (reset)
      ov_stop <= 1'b0;
    else
      ov_stop <= ov_s || (ov_stop && !ovrel_s);
  end

  // Switching clock runs whenever bias is up
  always_ff @(posedge mclk)
  begin
    if (reset || !bias_enable)
    begin
      sw_cnt <= '0;
      switch_clock_out <= 1'b0;
    end
    else if (sw_cnt == `LFS_SW_HALF)
    begin
      sw_cnt <= '0;
      switch_clock_out <= !switch_clock_out;
    end
    else
      sw_cnt <= sw_cnt + 7'h01;
  end

  assign period_start = bias_enable && (sw_cnt == `LFS_SW_HALF) && !switch_clock_out;

  // Truncated period plus one whole skipped period
  always_ff @(posedge mclk)
  begin
    if (reset)
      skip_cnt <= '0;
    else if (cyc_s)
      skip_cnt <= `LFS_SKIP_PERIODS;
    else if (period_start && (skip_cnt != 2'h0))
      skip_cnt <= skip_cnt - 2'h1;
  end

  ////////////////////////////////////////////////////////////////////
  // Soft start request

  logic ss_pending;
  logic dim_d;

  // Armed by any clear; fired by the next dimming rise
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ss_pending <= 1'b1;
      dim_d <= 1'b0;
      soft_start_go <= 1'b0;
    end
    else
    begin
      dim_d <= dim_s;
      soft_start_go <= 1'b0;
      if (clear_all)
        ss_pending <= 1'b1;
      else if (dim_s && !dim_d && ss_pending && (state == lfs_pkg::ST_ACTIVE))
      begin
        ss_pending <= 1'b0;
        soft_start_go <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Output drive

  logic run;
  assign run = (state == lfs_pkg::ST_ACTIVE) && en_s && !trip;

  // Registered gates; latched hazards drop them one edge after their flag sets
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      boost_gate <= 1'b0;
      sink_enable <= '0;
      disconnect_gate_on <= 1'b0;
      fault_pin_oe <= 1'b0;
    end
    else
    begin
      boost_gate <= run && dim_s && !ov_stop && !cyc_s
                    && (skip_cnt == 2'h0) && switch_clock_out;
      sink_enable <= (run && dim_s) ? ~(short_flag | open_flag) : '0;
      disconnect_gate_on <= run;
      fault_pin_oe <= trip || ((|short_flag) && !var_s);
    end
  end

  // Open drain: only ever pulls low
  assign fault_pin_out = 1'b0;
  assign bias_enable = (state != lfs_pkg::ST_SLEEP);

  ////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  localparam int SHUT_MAX = `LFS_SHUTDOWN_CYC;

  AST_DIM_CLEAR: assert property (
    dim_tif.expired && !set_any |=> !latched_any && bias_enable)
    else $error("dimming low did not clear faults");

  AST_SOFT_START: assert property (
    $rose(dim_s) && ss_pending && state == lfs_pkg::ST_ACTIVE && !clear_all
    |=> soft_start_go ##1 !soft_start_go)
    else $error("soft start not requested");

  AST_BIAS_ON: assert property (
    en_s |=> bias_enable)
    else $error("bias dropped while enabled");

  AST_SHORT_SINK: assert property (
    (|short_set) |-> ##2 ((sink_enable & $past(short_set, 2)) == 4'h0))
    else $error("shorted string still sinking");

  AST_SHORT_FAULT: assert property (
    (|short_set) && !var_s ##1 !var_s |=> fault_pin_oe)
    else $error("string short did not assert fault");

  AST_ALT_NO_FAULT: assert property (
    $past(var_s) && !$past(trip) |-> !fault_pin_oe)
    else $error("alternate variant asserted fault");

  AST_ARMED_ONLY: assert property (
    !(|reg_s) && short_flag == 4'h0 && !clear_all |=> short_flag == 4'h0)
    else $error("short detected while disarmed");

  AST_OV_NOT_LATCHED: assert property (
    ov_s && !latched_any && !set_any |=> !latched_any ##1 !fault_pin_oe)
    else $error("overvoltage latched a fault");

  AST_OV_STOP: assert property (
    ov_stop |=> !boost_gate)
    else $error("boost switching during overvoltage");

  AST_OV_RESUME: assert property (
    ov_stop && ovrel_s && !ov_s |=> !ov_stop)
    else $error("overvoltage hold not released");

  AST_SOV_OFF: assert property (
    sov_s |-> ##2 (!boost_gate && sink_enable == 4'h0) ##1 !boost_gate)
    else $error("secondary overvoltage did not stop");

  AST_CYCLE_SKIP: assert property (
    cyc_s && !latched_any && !set_any |=> !boost_gate && !latched_any)
    else $error("cycle limit mishandled");

  AST_SIL_OFF: assert property (
    sil_s |-> ##2 (!boost_gate && !disconnect_gate_on && sink_enable == 4'h0))
    else $error("secondary current limit did not shut down");

  AST_IOCP: assert property (
    iocp_s |-> ##[1:SHUT_MAX] (fault_pin_oe && !boost_gate && sink_enable == 4'h0))
    else $error("input overcurrent not handled in time");

  AST_IOCP_GATE: assert property (
    iocp_s |-> ##2 !disconnect_gate_on)
    else $error("disconnect gate still on");

  AST_LOCKOUT: assert property (
    state == lfs_pkg::ST_ACTIVE && lock_tif.expired && !en_tif.expired
    |=> state == lfs_pkg::ST_LOCKOUT)
    else $error("lockout not entered");

  AST_WAKE_CLEAR: assert property (
    state == lfs_pkg::ST_SLEEP && en_s && !set_any |=> !latched_any)
    else $error("wake did not clear faults");

  AST_LOCK_CLEAR: assert property (
    state == lfs_pkg::ST_LOCKOUT && !set_any |=> !latched_any && !disconnect_gate_on)
    else $error("lockout did not clear faults");

  COV_SHORT: cover property (|short_set ##2 fault_pin_oe);
  COV_OV_CYCLE: cover property (ov_stop ##[1:20] !ov_stop);
  COV_SOFT_START: cover property (dim_tif.expired ##[1:50] soft_start_go);
  COV_IOCP: cover property (iocp_s ##2 !disconnect_gate_on);

endmodule : lfs_fault_supervisor

// ===== test/lfs_host_model.sv
// Purpose: Host controller model driving the enable and dimming pins
// Assumes: Requests come from the bench in step with mclk
// Notes: Pins move only on the falling edge, never on the sampling edge
`timescale 1ns/100ps

module lfs_host_model
(
  input wire logic mclk,
  input wire logic req_enable,
  input wire logic req_dimming,
  output logic enable_pin,
  output logic dimming_pin
);
  logic held_enable;
  logic held_dimming;

  ////////////////////////////////////////////////////////////////////////
  // Known levels from time zero so the synchronisers start clean
  initial
  begin
    held_enable = 1'b0;
    held_dimming = 1'b0;
    enable_pin = 1'b0;
    dimming_pin = 1'b0;
  end

  // Capture on the rising edge so the bench never races the model
  always @(posedge mclk)
  begin
    held_enable <= req_enable;
    held_dimming <= req_dimming;
  end

  // A long low on enable is how the host puts the part to sleep
  always @(negedge mclk)
  begin
    enable_pin <= held_enable;
    dimming_pin <= held_dimming;
  end
endmodule : lfs_host_model

// ===== test/lfs_fault_supervisor_tb_top.sv
// Purpose: Self-checking bench of the fault supervisor
// Assumes: Short clear and lockout counts stand in for the long ones
// Notes: Outputs packed as boost, four sinks, disconnect, fault drive
`timescale 1ns/100ps

module lfs_fault_supervisor_tb_top;
  typedef struct packed
  {
    logic alt;
    logic [3:0] shrt;
    logic [3:0] regl;
    logic [3:0] nocur;
    logic [3:0] evt;
    logic [6:0] on;
    logic [6:0] off;
  } lfs_row_s;

  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic req_enable = 1'b0;
  logic req_dimming = 1'b0;
  logic enable_pin;
  logic dimming_pin;
  logic variant_alt = 1'b0;
  logic [3:0] shrt = 4'h0;
  logic [3:0] regl = 4'hF;
  logic [3:0] nocur = 4'h0;
  logic ov = 1'b0;
  logic ov_rel = 1'b1;
  logic sov = 1'b0;
  logic cyc = 1'b0;
  logic sil = 1'b0;
  logic iocp = 1'b0;
  logic lock = 1'b0;
  logic boost_gate;
  logic [3:0] sink_enable;
  logic disconnect_gate_on;
  logic fault_pin_out;
  logic fault_pin_oe;
  logic bias_enable;
  logic switch_clock_out;
  logic soft_start_go;
  logic [6:0] outs;
  logic clk_prev = 1'b0;
  int err_count = 0;
  int samples_checked = 0;
  int ss_count = 0;
  int toggles = 0;
  // Event order in evt: overvoltage, secondary overvoltage, secondary limit, input overcurrent
  lfs_row_s rows [8] = '{
    '{1'b0, 4'h0, 4'hF, 4'h0, 4'h0, 7'h7E, 7'h7E},
    '{1'b0, 4'h2, 4'h1, 4'h0, 4'h0, 7'h77, 7'h77},
    '{1'b1, 4'h2, 4'h1, 4'h0, 4'h0, 7'h76, 7'h76},
    '{1'b0, 4'h2, 4'h0, 4'h0, 4'h0, 7'h7E, 7'h7E},
    '{1'b0, 4'h0, 4'hF, 4'h0, 4'h4, 7'h01, 7'h01},
    '{1'b0, 4'h0, 4'hF, 4'h0, 4'h2, 7'h01, 7'h01},
    '{1'b0, 4'h0, 4'hF, 4'h0, 4'h1, 7'h01, 7'h01},
    '{1'b0, 4'h0, 4'hF, 4'h4, 4'h8, 7'h2E, 7'h6E}};

  ////////////////////////////////////////////////////////////////////////
  // Clock, host model and design
  always #2 mclk = ~mclk;

  assign outs = {boost_gate, sink_enable, disconnect_gate_on, fault_pin_oe};

  lfs_host_model host (.mclk(mclk), .req_enable(req_enable), .req_dimming(req_dimming),
    .enable_pin(enable_pin), .dimming_pin(dimming_pin));

  lfs_fault_supervisor #(.CLEAR_CYC(23'h000032), .LOCKOUT_CYC(23'h000014)) DUT (
    .mclk(mclk), .reset(reset), .enable_pin(enable_pin), .dimming_pin(dimming_pin),
    .variant_alt(variant_alt), .string_short_threshold(shrt), .sink_at_regulation(regl),
    .sink_no_current(nocur), .overvoltage_event(ov), .overvoltage_release(ov_rel),
    .secondary_overvoltage_event(sov), .cycle_current_limit_event(cyc),
    .secondary_switch_current_limit(sil), .input_sense_trip_level(iocp),
    .input_lockout_threshold(lock), .boost_gate(boost_gate), .sink_enable(sink_enable),
    .disconnect_gate_on(disconnect_gate_on), .fault_pin_out(fault_pin_out),
    .fault_pin_oe(fault_pin_oe), .bias_enable(bias_enable),
    .switch_clock_out(switch_clock_out), .soft_start_go(soft_start_go));

  // Soft-start pulses last one cycle, so they are counted as they pass
  always @(posedge mclk)
  begin
    if (soft_start_go === 1'b1)
      ss_count++;
    if (switch_clock_out !== clk_prev)
      toggles++;
    clk_prev <= switch_clock_out;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (err_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  task automatic cycles(input int n);
    repeat (n) @(negedge mclk);
  endtask : cycles

  task automatic check_out(input string what, input logic [6:0] exp, input logic [6:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check_out

  task automatic check_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic check_cnt(input string what, input int exp, input int got);
    samples_checked++;
    if (got != exp)
    begin
      err_count++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask : check_cnt

  // Bounded wait on the boost gate; a miss ends the run
  task automatic wait_boost(input logic v, input int lim);
    int i;
    for (i = 0; i < lim && boost_gate !== v; i++)
      @(negedge mclk);
    check_bit("boost_gate", v, boost_gate);
    if (i == lim)
      final_report();
  endtask : wait_boost

  // Boost follows the switching clock, so checks start on a fresh high phase
  task automatic sync_switch();
    int i;
    int j;
    for (i = 0; i < 140 && switch_clock_out !== 1'b0; i++)
      @(negedge mclk);
    for (j = 0; j < 140 && switch_clock_out !== 1'b1; j++)
      @(negedge mclk);
    if (i == 140 || j == 140)
    begin
      err_count++;
      $display("unexpected switch_clock_out: expected toggling, seen %b", switch_clock_out);
      final_report();
    end
  endtask : sync_switch

  // Idle inputs, long dimming low with enable high, then a dimming rise
  task automatic clear_by_dimming();
    int n;
    int t;
    {shrt, nocur, ov, sov, cyc, sil, iocp, variant_alt} = '0;
    regl = 4'hF;
    ov_rel = 1'b1;
    req_dimming = 1'b0;
    t = toggles;
    cycles(200);
    check_bit("bias_enable", 1'b1, bias_enable);
    check_bit("switch clock running", 1'b1, logic'(toggles - t >= 2));
    sync_switch();
    n = ss_count;
    req_dimming = 1'b1;
    cycles(8);
    check_cnt("soft start pulses", n + 1, ss_count);
    check_out("outputs after clear", 7'h7E, outs);
  endtask : clear_by_dimming

  ////////////////////////////////////////////////////////////////////////
  // Run length guard, well past the expected sequence
  initial
  begin
    #100000;
    err_count++;
    final_report();
  end

  // Main sequence: rows first, then hand-written awkward cases
  initial
  begin
    cycles(3);
    reset = 1'b0;
    check_out("outputs in reset", 7'h00, outs);
    lock = 1'b1;
    req_enable = 1'b1;
    cycles(20);
    clear_by_dimming();
    foreach (rows[i])
    begin
      sync_switch();
      {variant_alt, shrt, regl, nocur} = {rows[i].alt, rows[i].shrt, rows[i].regl, rows[i].nocur};
      {ov, sov, sil, iocp} = rows[i].evt;
      ov_rel = ~rows[i].evt[3];
      cycles(8);
      check_out("outputs during event", rows[i].on, outs);
      {shrt, ov, sov, sil, iocp} = '0;
      ov_rel = 1'b1;
      cycles(8);
      check_out("outputs after event", rows[i].off, outs);
      clear_by_dimming();
    end
    // A single cycle limit trip skips switching but sets no fault
    cyc = 1'b1;
    cycles(1);
    cyc = 1'b0;
    wait_boost(1'b0, 20);
    wait_boost(1'b1, 400);
    check_bit("fault_pin_oe", 1'b0, fault_pin_oe);
    // Two short dimming lows must not add up to a clear
    iocp = 1'b1;
    cycles(8);
    iocp = 1'b0;
    req_dimming = 1'b0;
    cycles(40);
    req_dimming = 1'b1;
    cycles(3);
    req_dimming = 1'b0;
    cycles(40);
    req_dimming = 1'b1;
    cycles(8);
    check_bit("fault_pin_oe", 1'b1, fault_pin_oe);
    clear_by_dimming();
    // Lockout glitch is filtered; a long lockout shuts down and clears
    sil = 1'b1;
    cycles(8);
    sil = 1'b0;
    lock = 1'b0;
    cycles(10);
    lock = 1'b1;
    cycles(8);
    check_out("outputs after glitch", 7'h01, outs);
    lock = 1'b0;
    cycles(40);
    check_out("outputs in lockout", 7'h00, outs);
    lock = 1'b1;
    cycles(20);
    check_bit("fault_pin_oe", 1'b0, fault_pin_oe);
    clear_by_dimming();
    // Sleep by long enable low; the next enable rise clears latches
    iocp = 1'b1;
    cycles(8);
    iocp = 1'b0;
    req_enable = 1'b0;
    cycles(80);
    check_bit("bias_enable", 1'b0, bias_enable);
    req_enable = 1'b1;
    cycles(20);
    check_bit("fault_pin_oe", 1'b0, fault_pin_oe);
    clear_by_dimming();
    check_bit("fault_pin_out", 1'b0, fault_pin_out);
    final_report();
  end
endmodule : lfs_fault_supervisor_tb_top
